// file: src/mdg_regs.vh
`ifndef MDG_REGS_VH
`define MDG_REGS_VH

// register index inside one channel's window, taken from io_addr[2:0]
`define MDG_IDX_ADDR_LO 3'h0
`define MDG_IDX_ADDR_HI 3'h1
`define MDG_IDX_LEN_LO 3'h2
`define MDG_IDX_CTRL 3'h3
`define MDG_IDX_LEN_HI 3'h4
`define MDG_IDX_IRQ_STAT 3'h5
`define MDG_IDX_IRQ_MASK 3'h6
`define MDG_IDX_REFR_CFG 3'h7

// io address layout: [7:5] group base, [4:3] straps, [2:0] index
`define MDG_BASE_MSB 7
`define MDG_BASE_LSB 5
`define MDG_BASE_DEFAULT 3'h1

// control register fields
`define MDG_CTRL_ENABLE 7
`define MDG_CTRL_FREERUN 4
`define MDG_CTRL_TO_RAM 0
`define MDG_CTRL_RESET 8'h00

// interrupt status and mask fields
`define MDG_IRQ_DONE 0
`define MDG_IRQ_RESET 8'h00

// refresh mode field, bits [1:0] of the refresh config register
`define MDG_REFR_OFF 2'h0
`define MDG_REFR_ONE_IN_4 2'h1
`define MDG_REFR_ONE_IN_8 2'h2
`define MDG_REFR_RESET 2'h0
`define MDG_REFR_ROWS 64
`define MDG_REFR_ROW_W 6

`endif

// file: src/mdg_refresh.v
`timescale 1ns/10ps
`include "mdg_regs.vh"

module mdg_refresh (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // slot input
  input wire slot_start,
  input wire [1:0] mode,
  // refresh outputs
  output wire refresh_take,
  output reg [`MDG_REFR_ROW_W-1:0] refresh_row_q
);

  reg [2:0] slot_cnt_q;

  assign refresh_take = slot_start & (
    ((mode == `MDG_REFR_ONE_IN_4) && (slot_cnt_q[1:0] == 2'h3)) ||
    ((mode == `MDG_REFR_ONE_IN_8) && (slot_cnt_q == 3'h7)));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt_q <= 3'h0;
      refresh_row_q <= {`MDG_REFR_ROW_W{1'b0}};
    end else begin
      if (slot_start) begin
        slot_cnt_q <= slot_cnt_q + 3'h1;
      end
      // six-bit row counter wraps after 64 rows, one full sweep
      if (refresh_take) begin
        refresh_row_q <= refresh_row_q + 6'h01;
      end
    end
  end

endmodule // mdg_refresh

// file: src/mdg_dma.v
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "mdg_regs.vh"


module mdg_dma #(
  parameter [2:0] BASE = `MDG_BASE_DEFAULT
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_wr,
  input wire io_rd,
  output reg [7:0] io_rdata_q,
  // straps and link pins
  input wire port_select_low,
  input wire port_select_high,
  input wire transfer_request_n,
  input wire mem_idle,
  // system address bus
  output reg [15:0] dma_addr_q,
  output reg dma_addr_oe_q,
  output reg data_write_select_q,
  output reg strobe_q,
  output reg xfer_q,
  output wire channel_enable,
  // refresh
  output reg refresh_active_q,
  output wire [`MDG_REFR_ROW_W-1:0] refresh_row,
  // interrupt
  output wire irq
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_XFER = 3'b010;
  localparam [2:0] ST_REFR = 3'b100;

  reg [2:0] state_q;
  reg [15:0] addr_q;
  reg [15:0] len_q;
  reg [7:0] ctrl_q;
  reg [7:0] irq_stat_q;
  reg [7:0] irq_mask_q;
  reg [1:0] refr_mode_q;
  reg [1:0] psl_sync_q;
  reg [1:0] psh_sync_q;
  reg [1:0] req_sync_q;
  reg [1:0] idle_sync_q;
  reg idle_prev_q;
  reg enable_prev_q;

  wire [1:0] straps;
  wire hit;
  wire [2:0] idx;
  wire wr_hit;
  wire rd_hit;
  wire idle_s;
  wire slot_start;
  wire slot_end;
  wire refresh_take;
  wire enable;
  wire last_byte;
  wire done_event;
  wire want_xfer;

  assign straps = {psh_sync_q[1], psl_sync_q[1]};
  assign idx = io_addr[2:0];
  assign hit = (io_addr[`MDG_BASE_MSB:`MDG_BASE_LSB] == BASE) &&
               (io_addr[4:3] == straps);
  assign wr_hit = io_wr & hit;
  assign rd_hit = io_rd & hit;
  assign idle_s = idle_sync_q[1];
  assign slot_start = idle_s & ~idle_prev_q;
  assign slot_end = ~idle_s & idle_prev_q;
  assign enable = ctrl_q[`MDG_CTRL_ENABLE];
  assign channel_enable = enable;
  assign last_byte = (len_q == 16'h0001);
  // request sampled at window start, so a late request waits one window
  assign want_xfer = enable & (ctrl_q[`MDG_CTRL_FREERUN] | ~req_sync_q[1]);
  assign done_event = enable_prev_q & ~enable;
  assign irq = |(irq_stat_q & irq_mask_q);

  mdg_refresh u_refresh (
    .clk(clk),
    .rst_n(rst_n),
    .slot_start(slot_start),
    .mode(refr_mode_q),
    .refresh_take(refresh_take),
    .refresh_row_q(refresh_row)
  );

  // pins pass two flops; first stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psl_sync_q <= 2'h0;
      psh_sync_q <= 2'h0;
      req_sync_q <= 2'h3;
      idle_sync_q <= 2'h0;
      idle_prev_q <= 1'b0;
      enable_prev_q <= 1'b0;
    end else begin
      psl_sync_q <= {psl_sync_q[0], port_select_low};
      psh_sync_q <= {psh_sync_q[0], port_select_high};
      req_sync_q <= {req_sync_q[0], transfer_request_n};
      idle_sync_q <= {idle_sync_q[0], mem_idle};
      idle_prev_q <= idle_s;
      enable_prev_q <= enable;
    end
  end

  // slot engine and channel registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      addr_q <= 16'h0000;
      len_q <= 16'h0000;
      ctrl_q <= `MDG_CTRL_RESET;
      refr_mode_q <= `MDG_REFR_RESET;
      irq_mask_q <= `MDG_IRQ_RESET;
      dma_addr_q <= 16'h0000;
      dma_addr_oe_q <= 1'b0;
      data_write_select_q <= 1'b0;
      strobe_q <= 1'b0;
      xfer_q <= 1'b0;
      refresh_active_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      xfer_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (refresh_take) begin
            state_q <= ST_REFR;
            refresh_active_q <= 1'b1;
          end else if (slot_start && want_xfer) begin
            state_q <= ST_XFER;
            dma_addr_q <= addr_q;
            dma_addr_oe_q <= 1'b1;
            data_write_select_q <= ctrl_q[`MDG_CTRL_TO_RAM];
            strobe_q <= 1'b1;
          end
        end
        ST_XFER: begin
          if (!enable) begin
            state_q <= ST_IDLE;
            dma_addr_oe_q <= 1'b0;
            data_write_select_q <= 1'b0;
          end else if (slot_end) begin
            state_q <= ST_IDLE;
            dma_addr_oe_q <= 1'b0;
            data_write_select_q <= 1'b0;
            xfer_q <= 1'b1;
            addr_q <= addr_q + 16'h0001;
            len_q <= len_q - 16'h0001;
            if (last_byte) begin
              ctrl_q[`MDG_CTRL_ENABLE] <= 1'b0;
            end
          end
        end
        ST_REFR: begin
          if (slot_end) begin
            state_q <= ST_IDLE;
            refresh_active_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // software writes on the write clock; a cleared enable stops transfer slots, refresh slots go on
      if (wr_hit) begin
        case (idx)
          `MDG_IDX_ADDR_LO: addr_q[7:0] <= io_wdata;
          `MDG_IDX_ADDR_HI: addr_q[15:8] <= io_wdata;
          `MDG_IDX_LEN_LO: len_q[7:0] <= io_wdata;
          `MDG_IDX_LEN_HI: len_q[15:8] <= io_wdata;
          `MDG_IDX_CTRL: ctrl_q <= io_wdata;
          `MDG_IDX_IRQ_MASK: irq_mask_q <= io_wdata;
          `MDG_IDX_REFR_CFG: refr_mode_q <= io_wdata[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // sticky done flag, read clears, a new event in that cycle wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= `MDG_IRQ_RESET;
    end else if (done_event) begin
      irq_stat_q[`MDG_IRQ_DONE] <= 1'b1;
    end else if (rd_hit && (idx == `MDG_IDX_IRQ_STAT)) begin
      irq_stat_q <= `MDG_IRQ_RESET;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_q <= 8'h00;
    end else if (rd_hit) begin
      case (idx)
        `MDG_IDX_ADDR_LO: io_rdata_q <= addr_q[7:0];
        `MDG_IDX_ADDR_HI: io_rdata_q <= addr_q[15:8];
        `MDG_IDX_LEN_LO: io_rdata_q <= len_q[7:0];
        `MDG_IDX_LEN_HI: io_rdata_q <= len_q[15:8];
        `MDG_IDX_CTRL: io_rdata_q <= ctrl_q;
        `MDG_IDX_IRQ_STAT: io_rdata_q <= irq_stat_q;
        `MDG_IDX_IRQ_MASK: io_rdata_q <= irq_mask_q;
        `MDG_IDX_REFR_CFG: io_rdata_q <= {6'h00, refr_mode_q};
        default: io_rdata_q <= 8'h00;
      endcase
    end else begin
      io_rdata_q <= 8'h00;
    end
  end

endmodule // mdg_dma

// file: tb/mdg_peer.sv
`timescale 1ns/10ps
module mdg_peer #(
  parameter [15:0] REF_ADDR = 16'h12FF
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // link pins
  input wire xfer_q,
  input wire hold,
  input wire strobe_q,
  input wire [15:0] dma_addr_q,
  output reg transfer_request_n,
  output reg mem_idle,
  // snoop results
  output reg [15:0] snoop_addr_q,
  output reg snoop_go_q
);
  reg [3:0] ph_q;
  // idle window is the last four of every ten cycles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 4'h0;
      mem_idle <= 1'b0;
      transfer_request_n <= 1'b1;
      snoop_addr_q <= 16'h0000;
      snoop_go_q <= 1'b0;
    end else begin
      ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
      mem_idle <= (ph_q > 4'h5);
      // lone channel, so it always wins; drops for a cycle after each byte
      transfer_request_n <= xfer_q | hold;
      // shared address bus: only the strobe pulse marks a dma address
      if (strobe_q) begin
        snoop_addr_q <= dma_addr_q;
        snoop_go_q <= (dma_addr_q > REF_ADDR);
      end
    end
  end
endmodule // mdg_peer

// file: tb/mdg_dma_properties.sv
`timescale 1ns/10ps
module mdg_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // link and refresh
  input wire [15:0] dma_addr_q,
  input wire dma_addr_oe_q,
  input wire data_write_select_q,
  input wire strobe_q,
  input wire xfer_q,
  input wire channel_enable,
  input wire refresh_active_q,
  input wire [5:0] refresh_row
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [15:0] last_addr_q;
  reg last_ok_q;
  // address of the last finished byte; forgotten when the channel stops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_addr_q <= 16'h0000;
      last_ok_q <= 1'b0;
    end else if (!channel_enable) begin
      last_ok_q <= 1'b0;
    end else if (xfer_q) begin
      last_addr_q <= dma_addr_q;
      last_ok_q <= 1'b1;
    end
  end
  sequence s_open;
    $rose(dma_addr_oe_q);
  endsequence
  sequence s_pulse;
    strobe_q ##1 !strobe_q;
  endsequence
  a_slot_strobe: assert property (s_open |-> s_pulse)
    else $error("strobe width");
  a_xfer_close: assert property (xfer_q |-> !dma_addr_oe_q && $past(dma_addr_oe_q))
    else $error("byte end");
  a_addr_step: assert property (strobe_q && last_ok_q |->
    dma_addr_q == last_addr_q + 16'h0001)
    else $error("address step");
  a_stop_quiet: assert property (!channel_enable ##1 !channel_enable |-> !strobe_q)
    else $error("strobe while off");
  a_enable_drop: assert property ($fell(channel_enable) |=> !dma_addr_oe_q)
    else $error("bus kept after stop");
  a_dws_slot: assert property (data_write_select_q |-> dma_addr_oe_q)
    else $error("select outside slot");
  a_refr_apart: assert property (refresh_active_q |-> !dma_addr_oe_q && !strobe_q)
    else $error("refresh overlaps");
  a_row_step: assert property ($changed(refresh_row) |->
    refresh_row == $past(refresh_row) + 6'h01)
    else $error("row step");
endmodule // mdg_chk

bind mdg_dma mdg_chk i_mdg_chk (.clk(clk), .rst_n(rst_n), .dma_addr_q(dma_addr_q),
  .dma_addr_oe_q(dma_addr_oe_q), .data_write_select_q(data_write_select_q),
  .strobe_q(strobe_q), .xfer_q(xfer_q), .channel_enable(channel_enable),
  .refresh_active_q(refresh_active_q), .refresh_row(refresh_row));

// file: tb/multi_channel_dma_system_glue_bench.sv
`timescale 1ns/10ps
module multi_channel_dma_system_glue_bench;
  localparam [7:0] hit = 8'h30;
  logic clk, rst_n, io_wr, io_rd, psl, psh, pr, irq, en, ra, xf, req_n, idle;
  logic [7:0] io_addr, io_wdata, io_rdata_q;
  logic [5:0] row;
  logic hold, stb, go;
  logic [15:0] dad, snoop;
  integer bad_count = 0, checked = 0, nx = 0, nr = 0, n, nb, r, m, e;
  mdg_peer i_mdg_peer (.clk(clk), .rst_n(rst_n), .xfer_q(xf), .hold(hold),
    .strobe_q(stb), .dma_addr_q(dad), .transfer_request_n(req_n), .mem_idle(idle),
    .snoop_addr_q(snoop), .snoop_go_q(go));
  mdg_dma i_mdg_dma (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata_q(io_rdata_q), .port_select_low(psl),
    .port_select_high(psh), .transfer_request_n(req_n), .mem_idle(idle), .dma_addr_q(dad),
    .dma_addr_oe_q(), .data_write_select_q(), .strobe_q(stb), .xfer_q(xf),
    .channel_enable(en), .refresh_active_q(ra), .refresh_row(row), .irq(irq));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    pr <= ra;
    if (xf) nx <= nx + 1;
    if (ra && !pr) nr <= nr + 1;
  end
  task chk(input [15:0] s, input [15:0] x);
    begin
      checked = checked + 1;
      if (s !== x) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] x);
    begin
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      @(negedge clk);
      chk(io_rdata_q, x);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    psl = 1'b0;
    psh = 1'b1;
    hold = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(hit + 8'h03, 8'h00);
    wr(8'h2B, 8'h80);
    rd(8'h2B, 8'h00);
    rd(hit + 8'h03, 8'h00);
    // three bytes that carry into the high address byte
    wr(hit, 8'hFE);
    wr(hit + 8'h01, 8'h12);
    wr(hit + 8'h02, 8'h03);
    wr(hit + 8'h04, 8'h00);
    wr(hit + 8'h06, 8'h01);
    n = nx;
    wr(hit + 8'h03, 8'h81);
    // let the enable write settle before polling it
    @(negedge clk);
    for (m = 0; m < 3000 && en !== 1'b0; m = m + 1) @(negedge clk);
    // last byte pulse is counted one edge after enable drops
    repeat (2) @(negedge clk);
    chk(nx - n, 3);
    chk(snoop, 16'h1300);
    chk(go, 1);
    rd(hit, 8'h01);
    rd(hit + 8'h01, 8'h13);
    chk(irq, 1);
    rd(hit + 8'h05, 8'h01);
    chk(irq, 0);
    // free run over a full-size buffer with refresh off, then stealing one slot in 4, then one in 8
    // request held off: an enabled channel without free run must not move
    @(posedge clk);
    hold <= 1'b1;
    wr(hit + 8'h02, 8'h00);
    wr(hit + 8'h03, 8'h81);
    n = nx;
    repeat (40) @(negedge clk);
    chk(nx - n, 0);
    @(posedge clk);
    hold <= 1'b0;
    wr(hit + 8'h03, 8'h91);
    for (m = 0; m < 3; m = m + 1) begin
      wr(hit + 8'h07, m[7:0]);
      repeat (12) @(negedge clk);
      n = nr;
      nb = nx;
      r = row;
      e = (m == 1) ? 10 : (m == 2) ? 5 : 0;
      repeat (400) @(negedge clk);
      chk(nr - n, e);
      chk(nx - nb, 40 - e);
      chk(row - r, e);
    end
    wr(hit + 8'h03, 8'h00);
    @(negedge clk);
    @(negedge clk);
    n = nx;
    repeat (40) @(negedge clk);
    chk(nx - n, 0);
    rd(hit + 8'h05, 8'h01);
    final_report;
  end
endmodule // multi_channel_dma_system_glue_bench
